// [logic/rst_seq_pkg.sv]
// package: constants, types and helpers of the reset time-out sequencer
package rst_seq_pkg;
  // clock rate and timing figures
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned BOR_FILT_US = 100;
  localparam int unsigned BOR_FILT_CYC = BOR_FILT_US * CLK_MHZ;
  localparam int unsigned BOR_CNT_W = 12;
  localparam int unsigned CPU_START_US = 5;
  localparam int unsigned CPU_START_CYC = CPU_START_US * CLK_MHZ;
  localparam int unsigned CPU_CNT_W = 8;
  localparam int unsigned OST_CYCLES = 1024;
  localparam int unsigned POWERUP_DELAY_TIMER_TIME_MS = 72;
  localparam int unsigned RC_OSC_KHZ = 32;
  localparam int unsigned POWERUP_DELAY_TIMER_TICKS_DEF = POWERUP_DELAY_TIMER_TIME_MS * RC_OSC_KHZ;
  // apb register byte offsets
  localparam logic [7:0] ADDR_POWER_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_SEQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RESUME_PC = 8'h0c;
  // power status fields
  localparam int unsigned PS_BOR_BIT = 0;
  localparam int unsigned PS_POR_BIT = 1;
  localparam logic [1:0] PS_RESET = 2'h0;
  // config fields
  localparam int unsigned CFG_POWERUP_DELAY_TIMER_N_BIT = 0;
  localparam int unsigned CFG_BOR_EN_BIT = 1;
  localparam int unsigned CFG_MODE_LSB = 2;
  localparam int unsigned CFG_W = 5;
  localparam logic [4:0] CFG_RESET = 5'h06;
  // asynchronous input positions in the synchroniser bundle
  localparam int unsigned IN_POR = 0;
  localparam int unsigned IN_BOR = 1;
  localparam int unsigned IN_PIN = 2;
  localparam int unsigned IN_RC = 3;
  localparam int unsigned IN_OSC = 4;
  localparam int unsigned IN_W = 5;
  // program counter values
  typedef logic [12:0] pc_t;
  localparam pc_t PC_RESET = 13'h0000;
  localparam pc_t PC_IRQ_VEC = 13'h0004;
  localparam pc_t PC_STEP = 13'h0001;
  // oscillator selection
  typedef enum logic [2:0] {
    OSC_LP = 3'b000, OSC_XT = 3'b001, OSC_HS = 3'b010, OSC_EXTCLK = 3'b011,
    OSC_INTERNAL_RC_OSC = 3'b100, OSC_INTERNAL_RC_OSC_IO = 3'b101, OSC_EXTERNAL_RC_MODE = 3'b110, OSC_EXTERNAL_RC_MODE_IO = 3'b111
  } osc_mode_t;
  // cause of the last reset or wake-up
  typedef enum logic [2:0] {
    CAUSE_POR = 3'b000, CAUSE_BOR = 3'b001, CAUSE_WDT_RST = 3'b010, CAUSE_PIN_RUN = 3'b011,
    CAUSE_PIN_SLEEP = 3'b100, CAUSE_WDT_WAKE = 3'b101, CAUSE_IRQ_WAKE = 3'b110
  } cause_t;
  // sequencer states
  typedef enum logic [2:0] {
    ST_RUN = 3'b000, ST_HOLD = 3'b001, ST_POWERUP_DELAY_TIMER = 3'b010, ST_OST = 3'b011, ST_FINISH = 3'b100
  } state_t;
  // crystal style modes need the oscillator start-up count
  function automatic logic is_crystal(input osc_mode_t m);
    return (m == OSC_LP) || (m == OSC_XT) || (m == OSC_HS);
  endfunction
  // supply related causes run the full time-out sequence
  function automatic logic is_power(input cause_t c);
    return (c == CAUSE_POR) || (c == CAUSE_BOR);
  endfunction
  // wake-ups resume the core instead of resetting it
  function automatic logic is_wake(input cause_t c);
    return (c == CAUSE_WDT_WAKE) || (c == CAUSE_IRQ_WAKE);
  endfunction
endpackage

// [logic/delay_if.sv]
// interface between the sequencer and one of its delay counters
interface delay_if;
  logic start; // one-cycle restart from zero
  logic tick; // one-cycle count event
  logic done; // level, delay expired
  modport ctl (output start, output tick, input done);
  modport cnt (input start, input tick, output done);
endinterface

// [logic/input_sync.sv]
// three-stage synchroniser with agreement filter for asynchronous inputs
module input_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw inputs and filtered results
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_r; // metastability catcher, read only by s2_r
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] lvl_r; // accepted level
  logic [W-1:0] lvl_nxt;

  // a change is accepted only once stages two and three agree
  always_comb
  begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < W; i++)
    begin
      if (s2_r[i] == s3_r[i])
      begin
        lvl_nxt[i] = s3_r[i];
      end
    end
  end

  // synchroniser chain and accepted level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end
    else
    begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level = lvl_r;
  assign rise = lvl_nxt & ~lvl_r;
  assign fall = ~lvl_nxt & lvl_r;
endmodule

// [logic/delay_counter.sv]
// tick counter that flags expiry after a fixed number of ticks
module delay_counter #(
  parameter int unsigned LIMIT = 1024,
  parameter int unsigned W = $clog2(LIMIT + 1)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control from the sequencer
  delay_if.cnt dly
);
  logic [W-1:0] cnt_r; // ticks seen since start
  logic run_r; // counting
  logic done_r; // expired

  // start always wins, so a restart mid-count begins from zero again
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end
    else if (dly.start)
    begin
      cnt_r <= '0;
      run_r <= 1'b1;
      done_r <= 1'b0;
    end
    else if (run_r && dly.tick)
    begin
      cnt_r <= cnt_r + W'(1);
      if (cnt_r == W'(LIMIT - 1))
      begin
        run_r <= 1'b0;
        done_r <= 1'b1;
      end
    end
  end

  assign dly.done = done_r;
endmodule

// [logic/reset_timeout_sequencer.sv]
// reset time-out sequencer: sources, delays, cause flags and apb registers
//
// Behaviour
// - supply rise starts time-out sequence
// - power-up delay holds reset, RC clocked
// - power-up delay only when enable_n clear
// - oscillator count 1024 after power-up delay
// - oscillator count: crystal modes, power/wake only
// - brownout_enable turns brown-out reset on
// - low supply beyond filter time resets
// - brown-out holds until supply recovers
// - low supply during delay restarts it
// - brown-out and power-up enables independent
// - delays in order, release after last
// - pin held past delays releases immediately
// - brown-out flag cleared by brown-out reset
// - brown-out flag meaningless when disabled
// - power-on flag cleared only by power-on
// - core start-up delay on power/wake
// - timeout and sleep flags encode cause
// - resets load zero, wakes resume
// - status upper bits per cause
// - power status changes only on power/brown-out
// - watchdog reset never drives the pin
// - watchdog wake leaves registers unchanged
module reset_timeout_sequencer #(
  parameter int unsigned POWERUP_DELAY_TIMER_TICKS = rst_seq_pkg::POWERUP_DELAY_TIMER_TICKS_DEF,
  parameter int unsigned OST_TICKS = rst_seq_pkg::OST_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous detectors, pin and oscillator inputs
  input wire logic por_detect,
  input wire logic brownout_low,
  input wire logic ext_reset_pin_n,
  input wire logic internal_rc_osc,
  input wire logic osc1_clk_in,
  // core side, same clock
  input wire logic watchdog_timeout,
  input wire logic sleep_active,
  input wire logic irq_wake,
  input wire logic global_irq_enable,
  input wire rst_seq_pkg::pc_t core_pc,
  // core control
  output logic core_reset_r,
  output logic wake_hold_r,
  output logic pc_load_r,
  output rst_seq_pkg::pc_t pc_value_r,
  output logic status_bank_clr_r,
  output logic timeout_flag_n_r,
  output logic sleep_entered_flag_n_r
);
  import rst_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisation and delay counters

  logic [IN_W-1:0] in_lvl; // filtered levels
  logic [IN_W-1:0] in_rise; // filtered rising edges
  logic [IN_W-1:0] in_fall; // filtered falling edges
  delay_if powerup_delay_timer_if ();
  delay_if ost_if ();

  // every pin and foreign clock passes the three-stage filter
  input_sync #(.W(IN_W)) u_sync (
    .clk (pclk),
    .rst_n (presetn),
    .async_in ({osc1_clk_in, internal_rc_osc, ext_reset_pin_n, brownout_low, por_detect}),
    .level (in_lvl),
    .rise (in_rise),
    .fall (in_fall)
  );

  // power-up delay, counted on internal RC edges
  delay_counter #(.LIMIT(POWERUP_DELAY_TIMER_TICKS)) u_powerup_delay_timer (
    .clk (pclk),
    .rst_n (presetn),
    .dly (powerup_delay_timer_if.cnt)
  );

  // oscillator start-up count, on external oscillator edges
  delay_counter #(.LIMIT(OST_TICKS)) u_ost (
    .clk (pclk),
    .rst_n (presetn),
    .dly (ost_if.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // registers and state

  state_t state_r; // sequencer state
  state_t state_nxt;
  cause_t cause_r; // cause being served / last served
  cause_t cause_nxt;
  logic [1:0] pstat_r; // power status flags
  logic [CFG_W-1:0] cfg_r; // configuration bits
  logic [BOR_CNT_W-1:0] bor_cnt_r; // brown-out filter count
  logic [CPU_CNT_W-1:0] cpu_cnt_r; // core start-up count
  logic cpu_done_r; // core start-up delay over
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // decoded config
  logic cfg_powerup_delay_timer_n;
  logic cfg_bor_en;
  osc_mode_t cfg_mode;
  assign cfg_powerup_delay_timer_n = cfg_r[CFG_POWERUP_DELAY_TIMER_N_BIT];
  assign cfg_bor_en = cfg_r[CFG_BOR_EN_BIT];
  assign cfg_mode = osc_mode_t'(cfg_r[CFG_MODE_LSB +: 3]);

  // source conditions
  logic pin_low; // pin held low
  logic bor_hold; // low supply, brown-out enabled
  logic bor_trip; // low supply outlasted the filter
  logic ev_valid; // a new source this cycle
  cause_t ev_cause;
  logic seq_done; // every required delay is over
  logic wr_en; // apb write commits
  assign pin_low = !in_lvl[IN_PIN];
  assign bor_hold = cfg_bor_en && in_lvl[IN_BOR];
  assign bor_trip = bor_hold && (bor_cnt_r == BOR_CNT_W'(BOR_FILT_CYC - 1));
  assign wr_en = psel && penable && pready_r && pwrite;

  ////////////////////////////////////////////////////////////////////////////////
  // source arbitration

  // priority: supply rise, brown-out, pin, watchdog, interrupt wake
  always_comb
  begin
    ev_valid = 1'b1;
    ev_cause = CAUSE_POR;
    if (in_rise[IN_POR])
    begin
      ev_cause = CAUSE_POR;
    end
    else if (bor_trip)
    begin
      ev_cause = CAUSE_BOR;
    end
    else if ((state_r == ST_RUN) ? pin_low : in_fall[IN_PIN])
    begin
      // a pin edge during a power sequence keeps the power cause
      if (state_r != ST_RUN && is_power(cause_r))
        ev_cause = cause_r;
      else
        ev_cause = sleep_active ? CAUSE_PIN_SLEEP : CAUSE_PIN_RUN;
    end
    else if (state_r == ST_RUN && watchdog_timeout)
    begin
      // watchdog only resets inside; the pin is an input here only
      ev_cause = sleep_active ? CAUSE_WDT_WAKE : CAUSE_WDT_RST;
    end
    else if (state_r == ST_RUN && irq_wake && sleep_active)
    begin
      ev_cause = CAUSE_IRQ_WAKE;
    end
    else
    begin
      ev_valid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  // core start-up delay only matters for power causes and wakes
  assign seq_done = cpu_done_r || !(is_power(cause_r) || is_wake(cause_r));

  // next state: hold, power-up delay, oscillator count, then release
  always_comb
  begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    case (state_r)
      ST_RUN:
      begin
        if (ev_valid && is_wake(ev_cause))
          state_nxt = is_crystal(cfg_mode) ? ST_OST : ST_FINISH;
        else if (ev_valid)
          state_nxt = ST_HOLD;
      end
      ST_HOLD:
      begin
        if (!bor_hold)
        begin
          if (!is_power(cause_r))
            state_nxt = ST_FINISH;
          else if (!cfg_powerup_delay_timer_n)
            state_nxt = ST_POWERUP_DELAY_TIMER;
          else
            state_nxt = is_crystal(cfg_mode) ? ST_OST : ST_FINISH;
        end
      end
      ST_POWERUP_DELAY_TIMER:
      begin
        if (powerup_delay_timer_if.done)
          state_nxt = is_crystal(cfg_mode) ? ST_OST : ST_FINISH;
      end
      ST_OST:
      begin
        if (ost_if.done)
          state_nxt = ST_FINISH;
      end
      ST_FINISH:
      begin
        // with delays already over, the pin edge releases at once
        if (seq_done && (!pin_low || is_wake(cause_r)))
          state_nxt = ST_RUN;
      end
      default:
      begin
        state_nxt = ST_HOLD;
      end
    endcase
    // a new source during the sequence restarts it from the hold
    if (ev_valid)
    begin
      cause_nxt = ev_cause;
      if (state_r != ST_RUN)
        state_nxt = ST_HOLD;
    end
  end

  // start pulses and ticks for the delay counters
  assign powerup_delay_timer_if.start = (state_nxt == ST_POWERUP_DELAY_TIMER) && (state_r != ST_POWERUP_DELAY_TIMER);
  assign powerup_delay_timer_if.tick = in_rise[IN_RC];
  assign ost_if.start = (state_nxt == ST_OST) && (state_r != ST_OST);
  assign ost_if.tick = in_rise[IN_OSC];

  // state and cause; reset itself counts as a power-on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_HOLD;
      cause_r <= CAUSE_POR;
    end
    else
    begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
    end
  end

  // brown-out filter: any gap in the low indication starts over
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bor_cnt_r <= '0;
    else if (!bor_hold)
      bor_cnt_r <= '0;
    else if (bor_cnt_r != BOR_CNT_W'(BOR_FILT_CYC))
      bor_cnt_r <= bor_cnt_r + BOR_CNT_W'(1);
  end

  // core start-up delay runs alongside the other timers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_cnt_r <= '0;
      cpu_done_r <= 1'b0;
    end
    else if (state_r == ST_RUN || state_r == ST_HOLD)
    begin
      cpu_cnt_r <= '0;
      cpu_done_r <= 1'b0;
    end
    else if (!cpu_done_r)
    begin
      cpu_cnt_r <= cpu_cnt_r + CPU_CNT_W'(1);
      cpu_done_r <= (cpu_cnt_r == CPU_CNT_W'(CPU_START_CYC - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // core outputs

  // separate reset and wake holds; wakes stall the core instead of resetting it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_reset_r <= 1'b1;
      wake_hold_r <= 1'b0;
    end
    else
    begin
      core_reset_r <= (state_nxt != ST_RUN) && !is_wake(cause_nxt);
      wake_hold_r <= (state_nxt != ST_RUN) && is_wake(cause_nxt);
    end
  end

  // program counter and status bank load on release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_load_r <= 1'b0;
      pc_value_r <= PC_RESET;
      status_bank_clr_r <= 1'b0;
    end
    else
    begin
      pc_load_r <= (state_r == ST_FINISH) && (state_nxt == ST_RUN);
      status_bank_clr_r <= (state_r == ST_FINISH) && (state_nxt == ST_RUN) &&
        !is_wake(cause_r);
      if (cause_r == CAUSE_IRQ_WAKE && global_irq_enable)
        pc_value_r <= PC_IRQ_VEC;
      else if (is_wake(cause_r))
        pc_value_r <= core_pc + PC_STEP;
      else
        pc_value_r <= PC_RESET;
    end
  end

  // timeout and sleep flags follow the captured cause
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timeout_flag_n_r <= 1'b1;
      sleep_entered_flag_n_r <= 1'b1;
    end
    else if (ev_valid)
    begin
      case (ev_cause)
        CAUSE_POR, CAUSE_BOR:
        begin
          timeout_flag_n_r <= 1'b1;
          sleep_entered_flag_n_r <= 1'b1;
        end
        CAUSE_WDT_RST:
        begin
          timeout_flag_n_r <= 1'b0;
          sleep_entered_flag_n_r <= 1'b1;
        end
        CAUSE_WDT_WAKE:
        begin
          timeout_flag_n_r <= 1'b0;
          sleep_entered_flag_n_r <= 1'b0;
        end
        CAUSE_PIN_SLEEP, CAUSE_IRQ_WAKE:
        begin
          timeout_flag_n_r <= 1'b1;
          sleep_entered_flag_n_r <= 1'b0;
        end
        default:
        begin
          // pin reset while running leaves both flags alone
          timeout_flag_n_r <= timeout_flag_n_r;
          sleep_entered_flag_n_r <= sleep_entered_flag_n_r;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb registers

  // power status: software sets, hardware clear wins in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pstat_r <= PS_RESET;
    else
    begin
      if (wr_en && paddr == ADDR_POWER_STATUS)
        pstat_r <= pwdata[1:0];
      if (ev_valid && ev_cause == CAUSE_POR)
        pstat_r[PS_POR_BIT] <= 1'b0;
      if (ev_valid && ev_cause == CAUSE_BOR)
        pstat_r[PS_BOR_BIT] <= 1'b0;
    end
  end

  // configuration bits steer the sequence
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_r <= CFG_RESET;
    else if (wr_en && paddr == ADDR_CONFIG)
      cfg_r <= pwdata[CFG_W-1:0];
  end

  // no wait state: data and answer are prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= psel && !penable;
      pslverr_r <= 1'b0;
      if (psel && !penable)
      begin
        case (paddr)
          ADDR_POWER_STATUS: prdata_r <= {30'h0, pstat_r};
          ADDR_CONFIG: prdata_r <= {27'h0, cfg_r};
          ADDR_SEQ_STATUS: prdata_r <= {22'h0, wake_hold_r, core_reset_r, cause_r,
            state_r, timeout_flag_n_r, sleep_entered_flag_n_r};
          ADDR_RESUME_PC: prdata_r <= {19'h0, pc_value_r};
          default:
          begin
            prdata_r <= '0;
            pslverr_r <= 1'b1; // unmapped address
          end
        endcase
      end
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_finish_ready;
    (state_r == ST_FINISH) && seq_done && !pin_low && !is_wake(cause_r) && !ev_valid;
  endsequence
  sequence s_released;
    (state_r == ST_RUN) && !core_reset_r;
  endsequence

  a_por_starts_seq: assert property (in_rise[IN_POR] |=> state_r == ST_HOLD)
    else $error("supply rise did not start the sequence");
  a_powerup_delay_timer_holds_reset: assert property ((state_r == ST_POWERUP_DELAY_TIMER) |=> core_reset_r)
    else $error("core left reset during power-up delay");
  a_powerup_delay_timer_enable_gate: assert property ($rose(state_r == ST_POWERUP_DELAY_TIMER) |-> !$past(cfg_powerup_delay_timer_n))
    else $error("power-up delay ran while disabled");
  a_ost_crystal_only: assert property ($rose(state_r == ST_OST) |-> $past(is_crystal(cfg_mode)))
    else $error("oscillator count outside crystal mode");
  a_bor_filter_len: assert property (bor_trip |-> $past(bor_hold, BOR_FILT_CYC - 1))
    else $error("brown-out tripped before filter time");
  a_bor_holds_seq: assert property ((state_r == ST_HOLD) && bor_hold |=> state_r == ST_HOLD)
    else $error("sequence left hold while supply low");
  a_cpu_delay_done: assert property ($fell(wake_hold_r) |-> $past(cpu_done_r))
    else $error("wake released before core start-up delay");
  a_por_flag_clear: assert property (ev_valid && ev_cause == CAUSE_POR |=> !pstat_r[PS_POR_BIT])
    else $error("power-on flag not cleared");
  a_wdt_flags: assert property (ev_valid && ev_cause == CAUSE_WDT_RST |=>
    !timeout_flag_n_r && sleep_entered_flag_n_r)
    else $error("watchdog reset flags wrong");
  a_reset_pc_zero: assert property (pc_load_r && !is_wake(cause_r) |-> pc_value_r == PC_RESET)
    else $error("reset did not load program counter zero");
  a_pin_release: assert property (s_finish_ready |=> s_released)
    else $error("release not immediate after pin high");
endmodule

// [tb/core_side_model.sv]
// far side model: the two oscillators and a core program counter
module core_side_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // core control from the sequencer, sleep state from the bench
  input wire logic core_reset_r,
  input wire logic sleep_active,
  input wire logic pc_load_r,
  input wire rst_seq_pkg::pc_t pc_value_r,
  // oscillators and program counter
  output logic internal_rc_osc,
  output logic osc1_clk_in,
  output rst_seq_pkg::pc_t core_pc
);
  timeunit 1ns;
  timeprecision 1ns;
  import rst_seq_pkg::*;
  logic [3:0] div_r; // shared divider for both oscillators
  // rc at pclk/16, crystal at pclk/8: slower than pclk/6 so the filter sees every edge
  assign internal_rc_osc = div_r[3];
  assign osc1_clk_in = div_r[2];
  //////////////////////////////////////////////////////////////////////////////
  // divider runs free, as real oscillators do
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_r <= 4'h0;
    else
      div_r <= div_r + 4'h1;
  end
  // program counter: frozen in reset and in sleep, so pc+1 on wake is well defined
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_pc <= 13'h0000;
    else if (pc_load_r)
      core_pc <= pc_value_r;
    else if (!core_reset_r && !sleep_active)
      core_pc <= core_pc + 13'h0001;
  end
endmodule

// [tb/reset_timeout_sequencer_test.sv]
// self-checking bench of the reset time-out sequencer
module reset_timeout_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  import rst_seq_pkg::*;
  // clock, reset and apb
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  // detectors, pin and core side
  logic brownout_low = 1'b0, ext_reset_pin_n = 1'b1, watchdog_timeout = 1'b0, por_detect = 1'b0;
  logic sleep_active = 1'b0, irq_wake = 1'b0, global_irq_enable = 1'b0;
  logic internal_rc_osc, osc1_clk_in, core_reset_r, wake_hold_r, pc_load_r, status_bank_clr_r;
  logic timeout_flag_n_r, sleep_entered_flag_n_r;
  pc_t core_pc, pc_value_r, exp_pc;
  int mismatches = 0, tests_run = 0, lat;
  //////////////////////////////////////////////////////////////////////////////
  // short delay counts keep the run small
  reset_timeout_sequencer #(.POWERUP_DELAY_TIMER_TICKS(8), .OST_TICKS(4)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .por_detect, .brownout_low, .ext_reset_pin_n, .internal_rc_osc, .osc1_clk_in,
    .watchdog_timeout, .sleep_active, .irq_wake, .global_irq_enable, .core_pc,
    .core_reset_r, .wake_hold_r, .pc_load_r, .pc_value_r, .status_bank_clr_r,
    .timeout_flag_n_r, .sleep_entered_flag_n_r);
  core_side_model partner (.pclk, .presetn, .core_reset_r, .sleep_active, .pc_load_r,
    .pc_value_r, .internal_rc_osc, .osc1_clk_in, .core_pc);
  initial forever #20 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////////////
  // verdict in one place
  task automatic end_of_test();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      mismatches++;
      end_of_test();
    end
  endtask
  // wait for the core release pulse, then judge pc, clear pulse and cause flags
  task automatic rel(input pc_t pc, input logic clr, input logic to_n, input logic pd_n);
    lat = 0;
    while (pc_load_r !== 1'b1 && lat < 8000)
    begin
      @(posedge pclk);
      lat++;
    end
    if (pc_load_r !== 1'b1)
    begin
      mismatches++;
      end_of_test();
    end
    chk({16'h0, status_bank_clr_r, timeout_flag_n_r, sleep_entered_flag_n_r, pc_value_r},
      {16'h0, clr, to_n, pd_n, pc});
  endtask
  // pulse one same-clock core input: interrupt wake when irq is set, else watchdog
  task automatic pulse(input logic irq);
    if (irq)
      irq_wake <= 1'b1;
    else
      watchdog_timeout <= 1'b1;
    @(posedge pclk);
    irq_wake <= 1'b0;
    watchdog_timeout <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // power-on: full delay chain, flags, register reset values, unmapped refusal
  task automatic power_on();
    rel(PC_RESET, 1'b1, 1'b1, 1'b1);
    chk(32'(lat >= 150), 32'h1);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rd, 32'h6);
    apb(1'b0, ADDR_POWER_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h0);
    apb(1'b1, ADDR_POWER_STATUS, 32'hffff_ffff);
    apb(1'b0, ADDR_POWER_STATUS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask
  // watchdog reset then pin held low past every delay
  task automatic wdt_and_pin();
    pulse(1'b0);
    rel(PC_RESET, 1'b1, 1'b0, 1'b1);
    ext_reset_pin_n <= 1'b0;
    repeat (600) @(posedge pclk);
    ext_reset_pin_n <= 1'b1;
    rel(PC_RESET, 1'b1, 1'b0, 1'b1);
    chk(32'(lat < 10), 32'h1);
    apb(1'b0, ADDR_POWER_STATUS, 32'h0);
    chk(rd, 32'h3);
  endtask
  // wake-ups: watchdog resumes at pc+1, interrupt with enable jumps to the vector
  task automatic wakes();
    sleep_active <= 1'b1;
    @(posedge pclk);
    exp_pc = core_pc + PC_STEP;
    pulse(1'b0);
    repeat (4) @(posedge pclk);
    chk({30'h0, core_reset_r, wake_hold_r}, 32'h1);
    rel(exp_pc, 1'b0, 1'b0, 1'b0);
    global_irq_enable <= 1'b1;
    pulse(1'b1);
    rel(PC_IRQ_VEC, 1'b0, 1'b1, 1'b0);
    sleep_active <= 1'b0;
    apb(1'b0, ADDR_RESUME_PC, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, ADDR_POWER_STATUS, 32'h0);
    chk(rd, 32'h3);
  endtask
  // brown-out: a short dip is filtered, a long one resets and clears bit 0
  task automatic brownout();
    brownout_low <= 1'b1;
    repeat (200) @(posedge pclk);
    brownout_low <= 1'b0;
    repeat (20) @(posedge pclk);
    chk(32'(core_reset_r), 32'h0);
    brownout_low <= 1'b1;
    repeat (2600) @(posedge pclk);
    chk(32'(core_reset_r), 32'h1);
    brownout_low <= 1'b0;
    rel(PC_RESET, 1'b1, 1'b1, 1'b1);
    apb(1'b0, ADDR_POWER_STATUS, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, ADDR_SEQ_STATUS, 32'h0);
    chk(rd, 32'h23);
  endtask
  // supply rise while running: power-on sequence again, power-on flag cleared
  task automatic supply_rise();
    por_detect <= 1'b1;
    repeat (10) @(posedge pclk);
    por_detect <= 1'b0;
    rel(PC_RESET, 1'b1, 1'b1, 1'b1);
    apb(1'b0, ADDR_POWER_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    power_on();
    wdt_and_pin();
    wakes();
    brownout();
    supply_rise();
    end_of_test();
  end
endmodule
